// ==== hdl/decode_io_pkg.sv ====
package decode_io_pkg;
   localparam int ADDR_W = 20;
   localparam logic [19:0] CTRL_LO = 20'h10000;
   localparam logic [19:0] CTRL_HI = 20'h100ff;
   localparam logic [19:0] BOOT_BASE = 20'h00000;
   localparam logic [19:0] BOOT_SIZE = 20'h02000;
   localparam logic [19:0] MAIN_BASE = 20'h20000;
   localparam logic [19:0] MAIN_SIZE = 20'h10000;
   localparam int NUM_MAIN = 8;
   localparam int NUM_BOOT = 4;
   localparam int NUM_PORTS = 7;
   localparam int NUM_IMC_PORTS = 3;
   localparam int NARROW_PORT = 3;
   localparam int NARROW_W = 4;
   localparam int CS_PORT = 2;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [7:0] DOUT_RESET = 8'h00;
   localparam logic [7:0] DRIVE_RESET = 8'h00;
   localparam logic [1:0] OSRC_RESET = 2'h0;
   localparam logic [1:0] IMC_RESET = 2'h0;

   typedef enum logic [1:0] {
      OSRC_DATA = 2'h0,
      OSRC_MCELL = 2'h1,
      OSRC_CS = 2'h3
   } out_src_type;

   typedef enum logic [1:0] {
      IMC_PASS = 2'h0,
      IMC_LATCH = 2'h1,
      IMC_REG = 2'h3
   } imc_mode_type;

   typedef enum logic [2:0] {
      RB_DOUT = 3'h0,
      RB_MCELL = 3'h1,
      RB_DIR = 3'h3,
      RB_DRIVE = 3'h2,
      RB_PIN = 3'h6,
      RB_IMC = 3'h7
   } rb_src_type;

   typedef enum logic [2:0] {
      WR_DOUT = 3'h0,
      WR_DIR = 3'h1,
      WR_DRIVE = 3'h3,
      WR_OSRC = 3'h2,
      WR_IMC = 3'h6
   } wr_sel_type;

   typedef struct packed {
      logic ctrl_sel;
      logic [NUM_MAIN-1:0] main_sector_selects;
      logic [NUM_BOOT-1:0] boot_segment_selects;
   } selects_type;
endpackage

// ==== hdl/input_macrocell.sv ====
`timescale 1ns/1ps
module input_macrocell
   import decode_io_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] pin_in,
   input wire logic [1:0] mode,
   input wire logic clk_term_lo,
   input wire logic clk_term_hi,
   output logic [W-1:0] imc_out
);
   logic [W-1:0] hold_r;
   logic [W-1:0] hold_nxt;
   logic [W-1:0] term_d_r;
   logic [W-1:0] term_d_nxt;
   logic [W-1:0] term;

   // low nibble on one term, high nibble on another
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign term[i] = (i < NARROW_W) ? clk_term_lo : clk_term_hi;
      end
   endgenerate

   // register on term rising edge, latch while term high
   always_comb begin
      term_d_nxt = term;
      hold_nxt = hold_r;
      for (int b = 0; b < W; b++) begin
         if (mode == IMC_REG && term[b] && !term_d_r[b]) begin
            hold_nxt[b] = pin_in[b];
         end else if (mode == IMC_LATCH && term[b]) begin
            hold_nxt[b] = pin_in[b];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hold_r <= '0;
         term_d_r <= '0;
      end else begin
         hold_r <= hold_nxt;
         term_d_r <= term_d_nxt;
      end
   end

   // transparent latch passes pin while open
   always_comb begin
      case (mode)
         IMC_PASS: imc_out = pin_in;
         IMC_LATCH: begin
            for (int b = 0; b < W; b++) begin
               imc_out[b] = term[b] ? pin_in[b] : hold_r[b];
            end
         end
         default: imc_out = hold_r;
      endcase
   end
endmodule

// ==== hdl/decode_io_ports.sv ====
`timescale 1ns/1ps
module decode_io_ports
   import decode_io_pkg::*;
#(
   parameter int PW = 8,
   parameter logic [PW-1:0] STATIC_DIR = DIR_RESET
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [ADDR_W-1:0] ADDRESS,
   input wire logic BANK_SELECT_N,
   input wire logic MAIN_BUSY,
   output selects_type SELECTS,
   output logic BOOT_READ_OK,
   input wire logic CFG_WE,
   input wire logic [2:0] CFG_PORT,
   input wire logic [2:0] CFG_WHAT,
   input wire logic [PW-1:0] CFG_DATA,
   input wire logic [2:0] RB_PORT,
   input wire logic [2:0] RB_SRC,
   output logic [PW-1:0] RB_DATA,
   input wire logic [NUM_PORTS*PW-1:0] PIN_IN,
   output logic [NUM_PORTS*PW-1:0] PIN_OUT,
   output logic [NUM_PORTS*PW-1:0] PIN_OE,
   output logic [NUM_PORTS*PW-1:0] PIN_OPEN_DRAIN,
   input wire logic [NUM_PORTS*PW-1:0] MCELL_OUT,
   input wire logic [NUM_PORTS*PW-1:0] MCELL_OE_TERM,
   input wire logic [NUM_PORTS*PW-1:0] MCELL_OE_DEFINED,
   input wire logic [PW-1:0] EXTERNAL_CHIP_SELECTS,
   input wire logic [NUM_IMC_PORTS-1:0] IMC_TERM_LO,
   input wire logic [NUM_IMC_PORTS-1:0] IMC_TERM_HI,
   output logic [NUM_IMC_PORTS*PW-1:0] IMC_TO_ARRAY
);
   selects_type sel_nxt;
   logic [PW-1:0] dout_r [NUM_PORTS];
   logic [PW-1:0] dout_nxt [NUM_PORTS];
   logic [PW-1:0] dir_r [NUM_PORTS];
   logic [PW-1:0] dir_nxt [NUM_PORTS];
   logic [PW-1:0] drive_r [NUM_PORTS];
   logic [PW-1:0] drive_nxt [NUM_PORTS];
   logic [2*PW-1:0] osrc_r [NUM_PORTS];
   logic [2*PW-1:0] osrc_nxt [NUM_PORTS];
   logic [2*PW-1:0] imc_r [NUM_IMC_PORTS];
   logic [2*PW-1:0] imc_nxt [NUM_IMC_PORTS];
   logic [PW-1:0] rb_nxt;
   logic [PW-1:0] rb_r;
   // macrocell words, zero on ports without macrocells
   logic [PW-1:0] imc_val [NUM_PORTS];
   logic [PW-1:0] mux_out [NUM_PORTS];
   logic [PW-1:0] port_mask [NUM_PORTS];
   // decoder window hits before bank qualification
   logic ctrl_hit;
   logic [NUM_BOOT-1:0] boot_hit;
   logic [NUM_MAIN-1:0] main_hit;
   genvar g;

   // control block window, inclusive bounds
   assign ctrl_hit = (ADDRESS >= CTRL_LO) && (ADDRESS <= CTRL_HI);

   // one comparator pair per boot segment and per main sector
   generate
      for (g = 0; g < NUM_BOOT; g++) begin : g_boot_win
         localparam logic [ADDR_W-1:0] LO = ADDR_W'(BOOT_BASE + g * BOOT_SIZE);
         localparam logic [ADDR_W-1:0] HI = ADDR_W'(BOOT_BASE + (g + 1) * BOOT_SIZE - 1);
         assign boot_hit[g] = (ADDRESS >= LO) && (ADDRESS <= HI);
      end
      for (g = 0; g < NUM_MAIN; g++) begin : g_main_win
         localparam logic [ADDR_W-1:0] LO = ADDR_W'(MAIN_BASE + g * MAIN_SIZE);
         localparam logic [ADDR_W-1:0] HI = ADDR_W'(MAIN_BASE + (g + 1) * MAIN_SIZE - 1);
         assign main_hit[g] = (ADDRESS >= LO) && (ADDRESS <= HI);
      end
   endgenerate

   // qualify with bank select, control block first
   always_comb begin
      sel_nxt = '0;
      if (!BANK_SELECT_N) begin
         if (ctrl_hit) begin
            sel_nxt.ctrl_sel = 1'b1;
         end else if (|boot_hit) begin
            sel_nxt.boot_segment_selects = boot_hit;
         end else begin
            sel_nxt.main_sector_selects = main_hit;
         end
      end
   end

   // boot array independent of main array activity
   assign BOOT_READ_OK = |SELECTS.boot_segment_selects;

   // per-port configuration writes, output source and macrocell mode copied to every pin of the port
   always_comb begin
      for (int p = 0; p < NUM_PORTS; p++) begin
         dout_nxt[p] = dout_r[p];
         dir_nxt[p] = dir_r[p];
         drive_nxt[p] = drive_r[p];
         osrc_nxt[p] = osrc_r[p];
         if (CFG_WE && CFG_PORT == 3'(p)) begin
            case (CFG_WHAT)
               WR_DOUT: dout_nxt[p] = CFG_DATA & port_mask[p];
               WR_DIR: dir_nxt[p] = CFG_DATA & port_mask[p];
               WR_DRIVE: drive_nxt[p] = CFG_DATA & port_mask[p];
               WR_OSRC: osrc_nxt[p] = {PW{CFG_DATA[1:0]}};
               default: ;
            endcase
         end
         dir_nxt[p] = dir_nxt[p] | (STATIC_DIR & port_mask[p]);
      end
      for (int p = 0; p < NUM_IMC_PORTS; p++) begin
         imc_nxt[p] = imc_r[p];
         if (CFG_WE && CFG_PORT == 3'(p) && CFG_WHAT == WR_IMC) begin
            imc_nxt[p] = {PW{CFG_DATA[1:0]}};
         end
      end
   end

   // decode result register
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         SELECTS <= '0;
      end else begin
         SELECTS <= sel_nxt;
      end
   end

   // port configuration registers
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            dout_r[p] <= DOUT_RESET;
            dir_r[p] <= DIR_RESET;
            drive_r[p] <= DRIVE_RESET;
            osrc_r[p] <= {PW{OSRC_RESET}};
         end
         for (int p = 0; p < NUM_IMC_PORTS; p++) begin
            imc_r[p] <= {PW{IMC_RESET}};
         end
      end else begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            dout_r[p] <= dout_nxt[p];
            dir_r[p] <= dir_nxt[p];
            drive_r[p] <= drive_nxt[p];
            osrc_r[p] <= osrc_nxt[p];
         end
         for (int p = 0; p < NUM_IMC_PORTS; p++) begin
            imc_r[p] <= imc_nxt[p];
         end
      end
   end

   // port pin mux and driver enable per port
   generate
      for (g = 0; g < NUM_PORTS; g++) begin : g_port
         localparam int WID = (g == NARROW_PORT) ? NARROW_W : PW;
         assign port_mask[g] = PW'((1 << WID) - 1);
         for (genvar b = 0; b < PW; b++) begin : g_pin
            localparam int IX = g * PW + b;
            logic [1:0] src;
            logic arr;
            assign src = osrc_r[g][2*b +: 2];
            // array source overrides data-out writes
            assign arr = (src == OSRC_MCELL) ||
                         (src == OSRC_CS && g == CS_PORT);
            assign mux_out[g][b] = (src == OSRC_CS && g == CS_PORT) ?
                                   EXTERNAL_CHIP_SELECTS[b] :
                                   (arr ? MCELL_OUT[IX] : dout_r[g][b]);
            assign PIN_OUT[IX] = mux_out[g][b] & port_mask[g][b];
            logic term_en;
            logic undef_en;
            // a defined enable term ORs with direction on any source
            assign term_en = MCELL_OE_DEFINED[IX] & MCELL_OE_TERM[IX];
            // array output with no enable equation always drives
            assign undef_en = arr & !MCELL_OE_DEFINED[IX];
            assign PIN_OE[IX] = port_mask[g][b] & (dir_r[g][b] | term_en | undef_en);
            assign PIN_OPEN_DRAIN[IX] = drive_r[g][b];
         end
      end
      for (g = 0; g < NUM_IMC_PORTS; g++) begin : g_imc
         input_macrocell #(.W(PW)) u_imc (
            .clk(CLK),
            .rst_n(RST_N),
            .pin_in(PIN_IN[g*PW +: PW]),
            .mode(imc_r[g][1:0]),
            .clk_term_lo(IMC_TERM_LO[g]),
            .clk_term_hi(IMC_TERM_HI[g]),
            .imc_out(imc_val[g])
         );
         assign IMC_TO_ARRAY[g*PW +: PW] = imc_val[g];
      end
      // ports without macrocells read back zero
      for (g = NUM_IMC_PORTS; g < NUM_PORTS; g++) begin : g_no_imc
         assign imc_val[g] = '0;
      end
   endgenerate

   // readback picks one source onto internal bus
   always_comb begin
      rb_nxt = '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
         if (RB_PORT == 3'(p)) begin
            case (RB_SRC)
               RB_DOUT: rb_nxt = dout_r[p];
               RB_MCELL: rb_nxt = MCELL_OUT[p*PW +: PW] & port_mask[p];
               RB_DIR: rb_nxt = dir_r[p];
               RB_DRIVE: rb_nxt = drive_r[p];
               RB_PIN: rb_nxt = PIN_IN[p*PW +: PW] & port_mask[p];
               RB_IMC: rb_nxt = imc_val[p];
               default: rb_nxt = '0;
            endcase
         end
      end
   end

   // readback data register
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rb_r <= '0;
      end else begin
         rb_r <= rb_nxt;
      end
   end

   assign RB_DATA = rb_r;
endmodule

// ==== tb/decode_io_chk.sv ====
`timescale 1ns/1ps
module decode_io_chk
   import decode_io_pkg::*;
#(
   parameter int PW = 8
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [ADDR_W-1:0] ADDRESS,
   input wire logic BANK_SELECT_N,
   input selects_type SELECTS,
   input wire logic BOOT_READ_OK,
   input wire logic CFG_WE,
   input wire logic [2:0] CFG_PORT,
   input wire logic [2:0] CFG_WHAT,
   input wire logic [PW-1:0] CFG_DATA,
   input wire logic [NUM_PORTS*PW-1:0] PIN_OUT,
   input wire logic [NUM_PORTS*PW-1:0] PIN_OE,
   input wire logic [NUM_PORTS*PW-1:0] MCELL_OE_TERM,
   input wire logic [NUM_PORTS*PW-1:0] MCELL_OE_DEFINED,
   input wire logic MAIN_BUSY
);
   logic [ADDR_W-1:0] addr_q;
   logic bank_n_q;
   logic busy_q;
   logic [NUM_PORTS*PW-1:0] term_on;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // bus inputs one edge back, to match the registered selects
   always_ff @(posedge CLK) begin
      addr_q <= ADDRESS;
      bank_n_q <= BANK_SELECT_N;
      busy_q <= MAIN_BUSY;
   end
   // defined enable terms, narrow port top nibble left out
   assign term_on = MCELL_OE_TERM & MCELL_OE_DEFINED & 56'hffffff0fffffff;
   // direction write to port 4 while its array enable term is idle
   sequence s_dir_wr;
      CFG_WE && CFG_WHAT == WR_DIR && CFG_PORT == 3'h4 ##1 MCELL_OE_TERM[39:32] == 8'h00;
   endsequence
   a_ctrl_range: assert property ($past(RST_N) |-> SELECTS.ctrl_sel ==
      (!bank_n_q && addr_q >= 20'h10000 && addr_q <= 20'h100ff)) else $error("ctrl sel");
   a_boot_segments: assert property ($past(RST_N) |-> SELECTS.boot_segment_selects ==
      ((!bank_n_q && addr_q <= 20'h07fff) ? 4'h1 << addr_q[14:13] : 4'h0))
      else $error("boot sel");
   a_main_sectors: assert property ($past(RST_N) |-> SELECTS.main_sector_selects ==
      ((!bank_n_q && addr_q >= 20'h20000 && addr_q <= 20'h9ffff) ?
      8'h01 << (addr_q[19:16] - 4'h2) : 8'h00)) else $error("main sel");
   a_select_count: assert property ($onehot0(SELECTS)) else $error("two selects");
   a_boot_ok: assert property ($past(RST_N) && busy_q && !bank_n_q && (addr_q <= 20'h07fff)
      |-> BOOT_READ_OK) else $error("boot read");
   a_dir_drives: assert property (s_dir_wr |-> PIN_OE[39:32] == $past(CFG_DATA))
      else $error("dir oe");
   a_term_enables: assert property ((PIN_OE & term_on) == term_on)
      else $error("term oe");
   a_narrow_quiet: assert property (PIN_OE[31:28] == 4'h0 && PIN_OUT[31:28] == 4'h0)
      else $error("narrow port");
endmodule
bind decode_io_ports decode_io_chk #(.PW(PW)) u_decode_io_chk (.CLK, .RST_N, .ADDRESS,
   .BANK_SELECT_N, .SELECTS, .BOOT_READ_OK, .CFG_WE, .CFG_PORT, .CFG_WHAT, .CFG_DATA,
   .PIN_OUT, .PIN_OE, .MCELL_OE_TERM, .MCELL_OE_DEFINED, .MAIN_BUSY);

// ==== tb/pin_model.sv ====
`timescale 1ns/1ps
module pin_model
   import decode_io_pkg::*;
(
   input wire logic [NUM_PORTS*8-1:0] pin_out,
   input wire logic [NUM_PORTS*8-1:0] pin_oe,
   input wire logic [NUM_PORTS*8-1:0] ext,
   output logic [NUM_PORTS*8-1:0] pin_in
);
   // wire level: the port where it drives, else the outside logic
   always_comb begin
      for (int i = 0; i < NUM_PORTS*8; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext[i];
      end
   end
endmodule

// ==== tb/test_dsp_decode_and_io_ports.sv ====
`timescale 1ns/1ps
module test_dsp_decode_and_io_ports
   import decode_io_pkg::*;
;
   logic CLK = '0, RST_N = '0, BANK_SELECT_N = '1, MAIN_BUSY = '0, CFG_WE = '0, BOOT_READ_OK;
   logic [19:0] ADDRESS = '0;
   logic [2:0] CFG_PORT = '0, CFG_WHAT = '0, RB_PORT = '0, RB_SRC = '0;
   logic [2:0] IMC_TERM_LO = '0, IMC_TERM_HI = '0;
   logic [7:0] CFG_DATA = '0, EXTERNAL_CHIP_SELECTS = '0, RB_DATA;
   logic [55:0] PIN_IN, PIN_OUT, PIN_OE, MCELL_OUT = '0, MCELL_OE_TERM = '0;
   logic [55:0] MCELL_OE_DEFINED = '0, ext = '0;
   logic [23:0] IMC_TO_ARRAY;
   logic [31:0] seed = 32'h9b1c1c51, r;
   logic [19:0] corner [13] = '{20'h00000, 20'h01fff, 20'h02000, 20'h07fff, 20'h08000,
      20'h0ffff, 20'h10000, 20'h100ff, 20'h10100, 20'h20000, 20'h3ffff, 20'h9ffff, 20'ha0000};
   selects_type SELECTS;
   int n_fail = 0, comparisons = 0;
   decode_io_ports u_decode_io_ports (.CLK, .RST_N, .ADDRESS, .BANK_SELECT_N, .MAIN_BUSY,
      .SELECTS, .BOOT_READ_OK, .CFG_WE, .CFG_PORT, .CFG_WHAT, .CFG_DATA, .RB_PORT, .RB_SRC,
      .RB_DATA, .PIN_IN, .PIN_OUT, .PIN_OE, .PIN_OPEN_DRAIN(), .MCELL_OUT, .MCELL_OE_TERM,
      .MCELL_OE_DEFINED, .EXTERNAL_CHIP_SELECTS, .IMC_TERM_LO, .IMC_TERM_HI, .IMC_TO_ARRAY);
   pin_model u_pin_model (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .ext(ext), .pin_in(PIN_IN));
   // xorshift source and expected decode
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic selects_type exp_sel(logic [19:0] a, logic bn);
      selects_type s;
      s = '0;
      if (!bn) begin
         s.ctrl_sel = a >= 20'h10000 && a <= 20'h100ff;
         if (a <= 20'h07fff) s.boot_segment_selects = 4'h1 << a[14:13];
         if (a >= 20'h20000 && a <= 20'h9ffff) s.main_sector_selects = 8'h01 << (a[19:16] - 4'h2);
      end
      return s;
   endfunction
   task automatic chk(logic [55:0] got, logic [55:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(int n = 1);
      repeat (n) @(posedge CLK);
      #1;
   endtask
   // one write strobe, then an idle edge
   task automatic cfg(logic [2:0] p, logic [2:0] w, logic [7:0] d);
      CFG_WE = '1;
      CFG_PORT = p;
      CFG_WHAT = w;
      CFG_DATA = d;
      step();
      CFG_WE = '0;
      step();
   endtask
   task automatic rb(logic [2:0] p, logic [2:0] s, logic [7:0] e);
      RB_PORT = p;
      RB_SRC = s;
      step();
      chk(56'(RB_DATA), 56'(e));
   endtask
   task automatic report_and_stop();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial forever #5 CLK = ~CLK;
   initial begin
      #100000;
      n_fail++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(posedge CLK);
      #1 RST_N = '1;
      step();
      chk(PIN_OE, '0);
      rb(3'h0, RB_DIR, 8'h00);
      // corners first, then random addresses, bank and busy
      for (int i = 0; i < 300; i++) begin
         r = rnd();
         ADDRESS = i < 13 ? corner[i] : (r[28] ? {4'h1, 8'h00, r[7:0]} : r[19:0]);
         BANK_SELECT_N = i < 13 ? 1'b0 : r[31] & r[30];
         MAIN_BUSY = r[29];
         step();
         chk(56'(SELECTS), 56'(exp_sel(ADDRESS, BANK_SELECT_N)));
         chk(56'(BOOT_READ_OK), 56'(!BANK_SELECT_N && ADDRESS <= 20'h07fff));
      end
      $display("test decode done");
      // per-port registers, pins and readback
      for (int p = 0; p < 7; p++) begin
         r = rnd();
         ext = {r[23:0], r};
         cfg(3'(p), WR_DOUT, r[7:0]);
         cfg(3'(p), WR_DIR, r[15:8]);
         cfg(3'(p), WR_DRIVE, r[23:16]);
         rb(3'(p), RB_DOUT, r[7:0] & (p == 3 ? 8'h0f : 8'hff));
         rb(3'(p), RB_DIR, r[15:8] & (p == 3 ? 8'h0f : 8'hff));
         rb(3'(p), RB_DRIVE, r[23:16] & (p == 3 ? 8'h0f : 8'hff));
         rb(3'(p), RB_PIN, (r[7:0] & r[15:8] | ext[p*8+:8] & ~r[15:8]) & (p == 3 ? 8'h0f : 8'hff));
         chk(56'(PIN_OE[p*8+:8]), 56'(r[15:8] & (p == 3 ? 8'h0f : 8'hff)));
         chk(56'(PIN_OUT[p*8+:8]), 56'(r[7:0] & (p == 3 ? 8'h0f : 8'hff)));
         cfg(3'(p), WR_DIR, 8'h00);
      end
      $display("test ports done");
      // macrocell and chip-select sources
      r = rnd();
      MCELL_OUT = {r[23:0], r};
      EXTERNAL_CHIP_SELECTS = r[31:24] ^ 8'h5a;
      cfg(3'h0, WR_OSRC, 8'h01);
      cfg(3'h2, WR_OSRC, 8'h03);
      cfg(3'h0, WR_DOUT, ~r[7:0]);
      chk(56'(PIN_OUT[7:0]), 56'(r[7:0]));
      chk(56'(PIN_OUT[23:16]), 56'(r[31:24] ^ 8'h5a));
      chk(56'(PIN_OE[7:0]), 56'hff);
      rb(3'h0, RB_DOUT, ~r[7:0]);
      rb(3'h0, RB_MCELL, r[7:0]);
      MCELL_OE_DEFINED[7:0] = 8'hff;
      MCELL_OE_TERM[7:0] = 8'h3c;
      step();
      chk(56'(PIN_OE[7:0]), 56'h3c);
      cfg(3'h0, WR_OSRC, 8'h00);
      chk(56'(PIN_OE[7:0]), 56'h3c);
      chk(56'(PIN_OUT[7:0]), 56'(r[7:0] ^ 8'hff));
      // mid-run reset returns every pin to input
      MCELL_OE_DEFINED = '0;
      cfg(3'h5, WR_DIR, 8'hff);
      chk(56'(PIN_OE[47:40]), 56'hff);
      RST_N = '0;
      step(2);
      RST_N = '1;
      step();
      chk(PIN_OE, '0);
      rb(3'h5, RB_DIR, 8'h00);
      $display("test sources done");
      // input macrocell on port 1: split register, latch, pass-through
      ext[15:8] = 8'ha5;
      cfg(3'h1, WR_IMC, 8'h03);
      IMC_TERM_LO[1] = '1;
      step();
      IMC_TERM_LO[1] = '0;
      ext[15:8] = 8'h5a;
      IMC_TERM_HI[1] = '1;
      step();
      IMC_TERM_HI[1] = '0;
      ext[15:8] = 8'h00;
      step(2);
      chk(56'(IMC_TO_ARRAY[15:8]), 56'h55);
      rb(3'h1, RB_IMC, 8'h55);
      cfg(3'h1, WR_IMC, 8'h01);
      ext[15:8] = 8'h3c;
      IMC_TERM_LO[1] = '1;
      IMC_TERM_HI[1] = '1;
      step(2);
      IMC_TERM_LO[1] = '0;
      IMC_TERM_HI[1] = '0;
      step();
      ext[15:8] = 8'hc3;
      step(2);
      chk(56'(IMC_TO_ARRAY[15:8]), 56'h3c);
      cfg(3'h1, WR_IMC, 8'h00);
      chk(56'(IMC_TO_ARRAY[15:8]), 56'hc3);
      $display("test macrocells done");
      report_and_stop();
   end
endmodule
